// ---- verilog/anpr_pkg.sv ----
`default_nettype none
package anpr_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [15:0] ANPR_OFF_LP_LOW   = 16'h0013;
	localparam logic [15:0] ANPR_OFF_LP_MID   = 16'h0014;
	localparam logic [15:0] ANPR_OFF_LP_HIGH  = 16'h0015;
	localparam logic [15:0] ANPR_OFF_NP_LOW   = 16'h0016;
	localparam logic [15:0] ANPR_OFF_NP_MID   = 16'h0017;
	localparam logic [15:0] ANPR_OFF_NP_HIGH  = 16'h0018;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [15:0] ANPR_RST_LP_LOW   = 16'h0001;
	localparam logic [15:0] ANPR_RST_LP_MID   = 16'h0000;
	localparam logic [15:0] ANPR_RST_LP_HIGH  = 16'h0000;
	localparam logic [15:0] ANPR_RST_NP_LOW   = 16'h2000;
	localparam logic [15:0] ANPR_RST_NP_MID   = 16'h0000;
	localparam logic [15:0] ANPR_RST_NP_HIGH  = 16'h0000;
	localparam logic [15:0] ANPR_ZERO16       = 16'h0000;
	localparam logic [4:0]  ANPR_SELECTOR     = 5'h01;

	// ****************************************
	// field positions
	// ****************************************
	localparam int ANPR_MORE_BIT   = 15;
	localparam int ANPR_RSVD_BIT   = 14;
	localparam int ANPR_MSG_BIT    = 13;
	localparam int ANPR_COMPLY_BIT = 12;
	localparam int ANPR_TOGGLE_BIT = 11;
	localparam int ANPR_SEL_HI     = 4;
	localparam int ANPR_SEL_LO     = 0;
	localparam int ANPR_WORD_W     = 16;
	localparam int ANPR_PAGE_W     = 48;
	localparam int ANPR_SEL_W      = 5;
	localparam int ANPR_LOW_LSB    = 0;
	localparam int ANPR_MID_LSB    = 16;
	localparam int ANPR_HIGH_LSB   = 32;

	// write mask of the low transmit register: reserved and toggle kept out
	localparam logic [15:0] ANPR_NP_LOW_WMASK = 16'hB7FF;
endpackage
`default_nettype wire

// ---- verilog/anpr_regs.sv ----
// Operation
// - partner low bit15 shows received more-pages flag
// - partner low bit14 shows received acknowledge
// - partner low bit13 shows received remote fault
// - partner low bits12:10 show pause capabilities
// - partner low bits9:5 show echoed nonce
// - partner selector field always reads 00001
// - partner mid bits15:8 hold page 31:24
// - partner mid bit7 holds page bit 23
// - partner mid bits6:5 hold page 22:21
// - partner mid bits4:0 hold sent nonce
// - partner high bit15 holds FEC request
// - partner high bit14 holds FEC capability
// - partner high bits13:0 hold page 45:32
// - transmit low bit15 writable, reset zero, sent
// - transmit low bit13 writable, reset one, sent
// - transmit low bit12 writable, reset zero, sent
// - toggle made by logic; bit11 only readback
// - transmit low bits10:0 writable, sent
// - transmit mid register sent as bits 31:16
// - transmit high register sent as bits 47:32
// - partner registers reset to 0001, 0000, 0000
`timescale 1ns/1ps
`default_nettype none
module anpr_regs
	import anpr_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic [15:0] reg_addr,
	input  wire logic        reg_wr_en,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_rd_en,
	output var  logic [15:0] reg_rdata_reg,
	output var  logic        reg_rd_valid_reg,
	input  wire logic [47:0] rx_page,
	input  wire logic        rx_page_valid,
	input  wire logic        tx_page_sent,
	output var  logic [47:0] tx_np_word_reg
);

	// ****************************************
	// decode
	// ****************************************
	function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
		hit = (a == o);
	endfunction

	// one 16-bit register word out of a 48-bit page
	function automatic logic [15:0] word_of(input logic [47:0] w,
		input int lsb);
		word_of = w[lsb +: ANPR_WORD_W];
	endfunction

	logic [15:0] lp_low_reg;
	logic [15:0] lp_mid_reg;
	logic [15:0] lp_high_reg;
	logic [15:0] snap_mid_reg;
	logic [15:0] snap_high_reg;
	logic        toggle_shadow_reg;
	logic [15:0] rdata_next;

	wire logic wr_np_low  = reg_wr_en && hit(reg_addr, ANPR_OFF_NP_LOW);
	wire logic wr_np_mid  = reg_wr_en && hit(reg_addr, ANPR_OFF_NP_MID);
	wire logic wr_np_high = reg_wr_en && hit(reg_addr, ANPR_OFF_NP_HIGH);
	wire logic rd_lp_low  = reg_rd_en && hit(reg_addr, ANPR_OFF_LP_LOW);

	// ****************************************
	// received base page capture
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			lp_low_reg  <= ANPR_RST_LP_LOW;
			lp_mid_reg  <= ANPR_RST_LP_MID;
			lp_high_reg <= ANPR_RST_LP_HIGH;
		end else if (rx_page_valid) begin
			lp_low_reg  <= {rx_page[ANPR_MORE_BIT:ANPR_SEL_W],
				ANPR_SELECTOR};
			lp_mid_reg  <= word_of(rx_page,
				ANPR_MID_LSB);
			lp_high_reg <= word_of(rx_page,
				ANPR_HIGH_LSB);
		end
	end

	// ****************************************
	// snapshot on low read
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			snap_mid_reg  <= ANPR_RST_LP_MID;
			snap_high_reg <= ANPR_RST_LP_HIGH;
		end else if (rd_lp_low) begin
			snap_mid_reg  <= lp_mid_reg;
			snap_high_reg <= lp_high_reg;
		end
	end

	// ****************************************
	// next page transmit word
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tx_np_word_reg <= {ANPR_RST_NP_HIGH, ANPR_RST_NP_MID,
				ANPR_RST_NP_LOW};
		end else begin
			if (wr_np_low) begin
				tx_np_word_reg[ANPR_LOW_LSB +: ANPR_WORD_W] <=
					(reg_wdata & ANPR_NP_LOW_WMASK) |
					(word_of(tx_np_word_reg, ANPR_LOW_LSB) &
					~ANPR_NP_LOW_WMASK);
				tx_np_word_reg[ANPR_TOGGLE_BIT] <=
					tx_np_word_reg[ANPR_TOGGLE_BIT] ^ tx_page_sent;
			end else if (tx_page_sent) begin
				tx_np_word_reg[ANPR_TOGGLE_BIT] <=
					~tx_np_word_reg[ANPR_TOGGLE_BIT];
			end
			if (wr_np_mid)
				tx_np_word_reg[ANPR_MID_LSB +: ANPR_WORD_W] <=
					reg_wdata;
			if (wr_np_high)
				tx_np_word_reg[ANPR_HIGH_LSB +: ANPR_WORD_W] <=
					reg_wdata;
		end
	end

	// toggle shadow keeps only what software wrote
	always_ff @(posedge clk_sys) begin
		if (reset)
			toggle_shadow_reg <= 1'b0;
		else if (wr_np_low)
			toggle_shadow_reg <= reg_wdata[ANPR_TOGGLE_BIT];
	end

	// ****************************************
	// read path
	// ****************************************
	always_comb begin
		rdata_next = ANPR_ZERO16;
		if (hit(reg_addr, ANPR_OFF_LP_LOW))
			rdata_next = {lp_low_reg[ANPR_MORE_BIT:ANPR_SEL_W],
				ANPR_SELECTOR};
		else if (hit(reg_addr, ANPR_OFF_LP_MID))
			rdata_next = snap_mid_reg;
		else if (hit(reg_addr, ANPR_OFF_LP_HIGH))
			rdata_next = snap_high_reg;
		else if (hit(reg_addr, ANPR_OFF_NP_LOW)) begin
			rdata_next = word_of(tx_np_word_reg, ANPR_LOW_LSB);
			rdata_next[ANPR_TOGGLE_BIT] = toggle_shadow_reg;
			rdata_next[ANPR_RSVD_BIT] = 1'b0;
		end else if (hit(reg_addr, ANPR_OFF_NP_MID))
			rdata_next = word_of(tx_np_word_reg, ANPR_MID_LSB);
		else if (hit(reg_addr, ANPR_OFF_NP_HIGH))
			rdata_next = word_of(tx_np_word_reg, ANPR_HIGH_LSB);
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			reg_rdata_reg    <= ANPR_ZERO16;
			reg_rd_valid_reg <= 1'b0;
		end else begin
			reg_rd_valid_reg <= reg_rd_en;
			if (reg_rd_en)
				reg_rdata_reg <= rdata_next;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_page_in;
		rx_page_valid && !rd_lp_low;
	endsequence
	sequence s_low_read;
		rd_lp_low && !rx_page_valid;
	endsequence
	sequence s_np_low_write;
		wr_np_low && !tx_page_sent;
	endsequence
	sequence s_mid_read;
		reg_rd_en && hit(reg_addr, ANPR_OFF_LP_MID);
	endsequence
	sequence s_high_read;
		reg_rd_en && hit(reg_addr, ANPR_OFF_LP_HIGH);
	endsequence
	sequence s_np_low_read;
		reg_rd_en && hit(reg_addr, ANPR_OFF_NP_LOW);
	endsequence
	sequence s_np_mid_read;
		reg_rd_en && hit(reg_addr, ANPR_OFF_NP_MID);
	endsequence
	sequence s_np_high_read;
		reg_rd_en && hit(reg_addr, ANPR_OFF_NP_HIGH);
	endsequence

	lp_flags_a: assert property (rx_page_valid |=>
		lp_low_reg[15:5] == $past(rx_page[15:5]))
		else $error("partner low flags not captured");
	sel_fixed_a: assert property (rd_lp_low |=>
		reg_rd_valid_reg && reg_rdata_reg[4:0] == ANPR_SELECTOR)
		else $error("selector field not 00001");
	snap_mid_a: assert property (s_page_in ##1 s_low_read ##1
		(reg_rd_en && hit(reg_addr, ANPR_OFF_LP_MID) && !rx_page_valid)
		|=> reg_rdata_reg == $past(rx_page[31:16], 3))
		else $error("mid read differs from captured page");
	snap_high_a: assert property (s_low_read |=>
		snap_high_reg == $past(lp_high_reg))
		else $error("high snapshot wrong");
	np_write_a: assert property (s_np_low_write |=>
		tx_np_word_reg[15] == $past(reg_wdata[15]) &&
		tx_np_word_reg[13:12] == $past(reg_wdata[13:12]) &&
		tx_np_word_reg[10:0] == $past(reg_wdata[10:0]))
		else $error("transmit low fields not sent");
	toggle_flip_a: assert property (tx_page_sent |=>
		tx_np_word_reg[ANPR_TOGGLE_BIT] !=
		$past(tx_np_word_reg[ANPR_TOGGLE_BIT]))
		else $error("toggle did not flip");
	shadow_rb_a: assert property (s_np_low_write ##1
		(reg_rd_en && hit(reg_addr, ANPR_OFF_NP_LOW) && !wr_np_low)
		|=> reg_rdata_reg[ANPR_TOGGLE_BIT] == $past(reg_wdata[11], 2) &&
		reg_rdata_reg[ANPR_RSVD_BIT] == 1'b0)
		else $error("toggle readback or reserved bit wrong");
	np_upper_a: assert property ((wr_np_mid || wr_np_high) |=>
		($past(wr_np_mid) -> tx_np_word_reg[31:16] == $past(reg_wdata)) &&
		($past(wr_np_high) -> tx_np_word_reg[47:32] == $past(reg_wdata)))
		else $error("transmit mid or high not sent");
	rst_val_a: assert property (disable iff (1'b0) reset |=>
		lp_low_reg == ANPR_RST_LP_LOW && lp_mid_reg == ANPR_RST_LP_MID &&
		tx_np_word_reg[15:0] == ANPR_RST_NP_LOW)
		else $error("reset values wrong");

	// ****************************************
	// capture checks
	// ****************************************
	lp_ack_a: assert property (rx_page_valid |=>
		lp_low_reg[14] == $past(rx_page[14]))
		else $error("partner acknowledge not captured");

	lp_fault_a: assert property (rx_page_valid |=>
		lp_low_reg[13] == $past(rx_page[13]))
		else $error("partner fault not captured");

	lp_pause_a: assert property (rx_page_valid |=>
		lp_low_reg[12:10] == $past(rx_page[12:10]))
		else $error("partner pause bits not captured");

	lp_echo_a: assert property (rx_page_valid |=>
		lp_low_reg[9:5] == $past(rx_page[9:5]))
		else $error("partner echoed nonce not captured");

	lp_sel_a: assert property ((rx_page_valid &&
		rx_page[4:0] != ANPR_SELECTOR) |=> lp_low_reg[4:0] == ANPR_SELECTOR)
		else $error("selector follows received bits");

	lp_tech_mid_a: assert property (rx_page_valid |=>
		lp_mid_reg[15:8] == $past(rx_page[31:24]))
		else $error("partner ability 10:3 not captured");

	lp_kr_a: assert property (rx_page_valid |=>
		lp_mid_reg[7] == $past(rx_page[23]))
		else $error("partner kr bit not captured");

	lp_kx_a: assert property (rx_page_valid |=>
		lp_mid_reg[6:5] == $past(rx_page[22:21]))
		else $error("partner bits 22:21 not captured");

	lp_nonce_a: assert property (rx_page_valid |=>
		lp_mid_reg[4:0] == $past(rx_page[20:16]))
		else $error("partner sent nonce not captured");

	lp_fec_req_a: assert property (rx_page_valid |=>
		lp_high_reg[15] == $past(rx_page[47]))
		else $error("partner fec request not captured");

	lp_fec_cap_a: assert property (rx_page_valid |=>
		lp_high_reg[14] == $past(rx_page[46]))
		else $error("partner fec ability not captured");

	lp_tech_high_a: assert property (rx_page_valid |=>
		lp_high_reg[13:0] == $past(rx_page[45:32]))
		else $error("partner ability 24:11 not captured");

	lp_hold_a: assert property (!rx_page_valid |=>
		$stable(lp_low_reg) && $stable(lp_mid_reg) && $stable(lp_high_reg))
		else $error("partner registers changed without a page");

	// ****************************************
	// snapshot checks
	// ****************************************
	snap_hold_a: assert property (!rd_lp_low |=>
		$stable(snap_mid_reg) && $stable(snap_high_reg))
		else $error("snapshot changed without a low read");

	snap_take_a: assert property (rd_lp_low |=>
		snap_mid_reg == $past(lp_mid_reg))
		else $error("mid snapshot wrong");

	mid_rd_a: assert property (s_mid_read |=>
		reg_rdata_reg == $past(snap_mid_reg))
		else $error("mid read not from snapshot");

	high_rd_a: assert property (s_high_read |=>
		reg_rdata_reg == $past(snap_high_reg))
		else $error("high read not from snapshot");

	// ****************************************
	// transmit checks
	// ****************************************
	np_msg_a: assert property (s_np_low_write |=>
		tx_np_word_reg[13] == $past(reg_wdata[13]))
		else $error("message page flag not sent");

	np_comply_a: assert property (s_np_low_write |=>
		tx_np_word_reg[12] == $past(reg_wdata[12]))
		else $error("comply flag not sent");

	np_code_a: assert property (s_np_low_write |=>
		tx_np_word_reg[10:0] == $past(reg_wdata[10:0]))
		else $error("code field not sent");

	toggle_keep_a: assert property (!tx_page_sent |=>
		$stable(tx_np_word_reg[ANPR_TOGGLE_BIT]))
		else $error("toggle moved without a sent page");

	toggle_wr_a: assert property ((wr_np_low && tx_page_sent) |=>
		tx_np_word_reg[ANPR_TOGGLE_BIT] !=
		$past(tx_np_word_reg[ANPR_TOGGLE_BIT]))
		else $error("toggle lost on write");

	np_low_hold_a: assert property (!wr_np_low |=>
		$stable(tx_np_word_reg[15:12]) && $stable(tx_np_word_reg[10:0]))
		else $error("transmit low changed without a write");

	rsvd_rd_a: assert property (s_np_low_read |=>
		reg_rdata_reg[ANPR_RSVD_BIT] == 1'b0 &&
		tx_np_word_reg[ANPR_RSVD_BIT] == 1'b0)
		else $error("reserved bit not zero");

	np_mid_hold_a: assert property (!wr_np_mid |=>
		$stable(tx_np_word_reg[31:16]))
		else $error("transmit mid changed without a write");

	np_high_hold_a: assert property (!wr_np_high |=>
		$stable(tx_np_word_reg[47:32]))
		else $error("transmit high changed without a write");

	np_mid_rb_a: assert property (s_np_mid_read |=>
		reg_rdata_reg == $past(tx_np_word_reg[31:16]))
		else $error("transmit mid readback wrong");

	np_high_rb_a: assert property (s_np_high_read |=>
		reg_rdata_reg == $past(tx_np_word_reg[47:32]))
		else $error("transmit high readback wrong");

	// ****************************************
	// read port checks
	// ****************************************
	rd_valid_a: assert property (reg_rd_en |=> reg_rd_valid_reg)
		else $error("read answer missing");

	rd_idle_a: assert property (!reg_rd_en |=>
		!reg_rd_valid_reg && $stable(reg_rdata_reg))
		else $error("read answer without a read");

	unmapped_rd_a: assert property ((reg_rd_en &&
		!(reg_addr inside {[ANPR_OFF_LP_LOW:ANPR_OFF_NP_HIGH]})) |=>
		reg_rdata_reg == ANPR_ZERO16)
		else $error("unmapped read not zero");

	rst_upper_a: assert property (disable iff (1'b0) reset |=>
		lp_high_reg == ANPR_RST_LP_HIGH &&
		tx_np_word_reg[47:16] == {ANPR_RST_NP_HIGH, ANPR_RST_NP_MID} &&
		snap_mid_reg == ANPR_RST_LP_MID && !reg_rd_valid_reg)
		else $error("upper reset values wrong");

endmodule // anpr_regs
`default_nettype wire

// ---- verif/anpr_link_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// remote page driver
// ****************************************
module anpr_link_model (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        cap_req,
	input  wire logic [47:0] cap_page,
	input  wire logic        snd_req,
	output var  logic [47:0] rx_page,
	output var  logic        rx_page_valid,
	output var  logic        tx_page_sent
);
	// page shown for one valid cycle, inverted every cycle otherwise
	always_ff @(posedge clk_sys) begin
		rx_page_valid <= cap_req & ~reset;
		rx_page <= reset ? 48'h0 : (cap_req ? cap_page : ~rx_page);
	end
	always_ff @(posedge clk_sys) begin
		tx_page_sent <= snd_req & ~reset;
	end
endmodule // anpr_link_model
`default_nettype wire

// ---- verif/anpr_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module autoneg_partner_page_and_next_page_regs_test;
	import anpr_pkg::*;
	logic        clk_sys = 1'b0, reset = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
	logic        rd_valid, rxv, sent, cap = 1'b0, snd = 1'b0, tog = 1'b0;
	logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, w;
	logic [15:0] s = 16'h003B;
	logic [47:0] rxp, txw, p, pg = 48'h0, snap = 48'h0;
	int          n_errors = 0, n_tests = 0, k;
	initial forever #50 clk_sys = ~clk_sys;
	anpr_regs u_dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(addr),
		.reg_wr_en(wr_en), .reg_wdata(wdata), .reg_rd_en(rd_en),
		.reg_rdata_reg(rdata), .reg_rd_valid_reg(rd_valid), .rx_page(rxp),
		.rx_page_valid(rxv), .tx_page_sent(sent), .tx_np_word_reg(txw));
	anpr_link_model u_link (.clk_sys(clk_sys), .reset(reset), .cap_req(cap),
		.cap_page(pg), .snd_req(snd), .rx_page(rxp), .rx_page_valid(rxv),
		.tx_page_sent(sent));
	function automatic logic [15:0] nx();
		s = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
		return s;
	endfunction
	function automatic logic [15:0] exp_np_low(input logic [15:0] d,
		input logic t);
		return (d & ANPR_NP_LOW_WMASK) | {4'h0, t, 11'h000};
	endfunction
	task chk(input string nm, input logic [47:0] seen, input logic [47:0] e);
		n_tests++;
		if (seen !== e) begin
			n_errors++;
			$display("unexpected %s exp %h seen %h", nm, e, seen);
		end
	endtask
	task close_out;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk_sys);
		wr_en <= 1'b0;
		@(negedge clk_sys);
	endtask
	task rd(input logic [15:0] a, input logic [15:0] e);
		int i;
		@(posedge clk_sys);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		@(negedge clk_sys);
		for (i = 0; i < 4 && rd_valid !== 1'b1; i++) @(negedge clk_sys);
		if (rd_valid !== 1'b1) begin
			n_errors++;
			close_out();
		end
		chk("rdata", {32'h0, rdata}, {32'h0, e});
	endtask
	task cap_page(input logic [47:0] v);
		@(posedge clk_sys);
		cap <= 1'b1;
		pg <= v;
		@(posedge clk_sys);
		cap <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
	task send_page;
		@(posedge clk_sys);
		snd <= 1'b1;
		@(posedge clk_sys);
		snd <= 1'b0;
		tog = ~tog;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		@(negedge clk_sys);
		chk("tx", txw, 48'h2000);
		rd(ANPR_OFF_LP_MID, 16'h0000);
		rd(ANPR_OFF_LP_LOW, ANPR_RST_LP_LOW);
		rd(ANPR_OFF_LP_HIGH, 16'h0000);
		rd(ANPR_OFF_NP_LOW, ANPR_RST_NP_LOW);
		rd(ANPR_OFF_NP_MID, 16'h0000);
		rd(ANPR_OFF_NP_HIGH, 16'h0000);
		for (k = 0; k < 8; k++) begin
			p = (k == 0) ? 48'hFFFF_FFFF_FFFF : {nx(), nx(), nx()};
			cap_page(p);
			rd(ANPR_OFF_LP_MID, snap[31:16]);
			rd(ANPR_OFF_LP_LOW, {p[15:5], ANPR_SELECTOR});
			snap = p;
			rd(ANPR_OFF_LP_MID, p[31:16]);
			rd(ANPR_OFF_LP_HIGH, p[47:32]);
			w = (k == 0) ? 16'hFFFF : nx();
			wr(ANPR_OFF_NP_LOW, w);
			chk("tx low", {32'h0, txw[15:0]}, {32'h0, exp_np_low(w, tog)});
			rd(ANPR_OFF_NP_LOW, w & 16'hBFFF);
			w = nx();
			wr(ANPR_OFF_NP_MID, w);
			chk("tx mid", {32'h0, txw[31:16]}, {32'h0, w});
			w = nx();
			wr(ANPR_OFF_NP_HIGH, w);
			chk("tx high", {32'h0, txw[47:32]}, {32'h0, w});
			send_page();
			chk("toggle", {47'h0, txw[11]}, {47'h0, tog});
		end
		wr(ANPR_OFF_LP_LOW, 16'h0000);
		rd(ANPR_OFF_LP_LOW, {p[15:5], ANPR_SELECTOR});
		wr(16'h0019, 16'hFFFF);
		rd(16'h0019, 16'h0000);
		close_out();
	end
endmodule // autoneg_partner_page_and_next_page_regs_test
`default_nettype wire
